// file: fcs_defines.vh
// Constants for the flash checksum, security set and read command block
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH
`define FCS_HDR_CMD 8'h01
`define FCS_HDR_DATA 8'h02
`define FCS_FTR_LAST 8'h03
`define FCS_FTR_MORE 8'h17
`define FCS_LEN_ADDR_CMD 8'h07
`define FCS_LEN_SEC_CMD 8'h03
`define FCS_LEN_ONE 8'h01
`define FCS_LEN_TWO 8'h02
`define FCS_LEN_FULL 8'h00
`define FCS_CMD_CSUM 8'hB0
`define FCS_CMD_SEC 8'hA0
`define FCS_CMD_READ 8'h50
`define FCS_ACK 8'h06
`define FCS_NACK 8'h15
`define FCS_PROTECT 8'h10
`define FCS_ZERO8 8'h00
`define FCS_FLG_FIXED 8'hE0
`define FCS_FLG_INIT 8'hFF
`define FCS_BIT_BOOT 4
`define FCS_BIT_READ 3
`define FCS_BIT_PROG 2
`define FCS_BIT_BERS 1
`define FCS_BIT_CERS 0
`define FCS_BLK_MASK 24'h0007FF
`define FCS_ADDR_W 24
`define FCS_CNT_W 9
`define FCS_CNT_FULL 9'h100
`define FCS_CNT_ONE 9'h001
`define FCS_ADDR_ONE 24'h000001
`define FCS_ADDR_ZERO 24'h000000
`define FCS_ADDR_FULL 24'h000100
`endif

// file: fcs_cmd.v
// Command interpreter for checksum, security set and read commands
`timescale 1ns/100ps
`default_nettype none
`include "fcs_defines.vh"
// Functional notes
// - Checksum starts at 00H and subtracts every range byte in turn.
// - Accepted checksum command answered by one-byte status frame 02H 01H.
// - Checksum data frame length 02H, high sum byte then low byte.
// - Device returns write result status, then internal verify status.
// - Flag bit 4 low protects boot cluster from rewriting.
// - Flag bit 3 high permits reading; low blocks it.
// - Bits 2,1,0 enable program, block erase, chip erase; bits 7-5 one.
// - Once set, further setting outside self-programming, or any re-enabling, reports protect error 10H.
// - Only chip erase restores flags; block erase leaves them.
// - Cleared chip erase enable rejects chip erase.
// - Boot protection rejects boot area program and block erase.
// - Self-programming mode ignores flags; may only narrow flags.
// - Read data frames, length 00H means 256, footer 17H, last 03H.
// - Command frames are 01H, length, command, parameters, checksum, 03H.
module fcs_cmd (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Received frame bytes from the link layer
  input wire rx_valid,
  input wire [7:0] rx_data,
  // Transmit bytes to the link layer
  output reg tx_valid_r,
  output reg [7:0] tx_data_r,
  input wire tx_ready,
  // Flash read port, data valid one cycle after request
  output reg fl_rd_r,
  output reg [23:0] fl_addr_r,
  input wire [7:0] fl_rdata,
  // Mode and erase events from the core
  input wire self_prog_mode,
  input wire chip_erase_done,
  input wire [23:0] boot_area_end,
  input wire [23:0] op_addr,
  // Security state seen by the rest of the device
  output reg [7:0] protection_flag_byte_r,
  output reg [7:0] boot_cluster_last_block_r,
  output reg security_set_r,
  output reg prog_allow_r,
  output reg block_erase_allow_r,
  output reg chip_erase_allow_r,
  output reg read_allow_r,
  output reg busy_r
);
  localparam S_IDLE = 4'h0;
  localparam S_RXCMD = 4'h1;
  localparam S_STATUS = 4'h2;
  localparam S_SUM = 4'h3;
  localparam S_SECDATA = 4'h4;
  localparam S_SECWR = 4'h5;
  localparam S_TX = 4'h6;
  localparam S_RDWAIT = 4'h7;
  localparam S_ACKWAIT = 4'h8;
  localparam K_STAT = 2'h0;
  localparam K_CSUM = 2'h1;
  localparam K_READ = 2'h2;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [3:0] idx_r;
  reg [7:0] cmd_r;
  reg [7:0] len_r;
  reg [7:0] buf_r [0:9];
  reg [23:0] addr_r;
  reg [23:0] end_r;
  reg [15:0] sum_r;
  reg [7:0] stat_r;
  reg [1:0] kind_r;
  reg verify_pend_r;
  reg [3:0] tx_pos_r;
  reg [8:0] tx_cnt_r;
  reg [7:0] fsum_r;
  reg last_frame_r;
  reg [7:0] rd_byte_r;
  reg rd_pend_r;
  wire [23:0] sa = {buf_r[2], buf_r[3], buf_r[4]};
  wire [23:0] ea = {buf_r[5], buf_r[6], buf_r[7]};
  // End address is a block's last byte, start a block's first
  wire range_bad = ((sa & `FCS_BLK_MASK) != `FCS_ADDR_ZERO) ||
    ((ea & `FCS_BLK_MASK) != `FCS_BLK_MASK) || (ea < sa);
  wire [7:0] new_flg = buf_r[2] | `FCS_FLG_FIXED;
  // A cleared bit may never be set again once protection exists
  wire reenable = |(new_flg & ~protection_flag_byte_r);
  // Full width: a whole range is far more than one frame
  wire [23:0] remain = end_r - addr_r + `FCS_ADDR_ONE;
  wire in_boot = (op_addr <= boot_area_end);
  wire boot_lock = ~protection_flag_byte_r[`FCS_BIT_BOOT] && ~self_prog_mode;
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      prog_allow_r <= 1'b1;
      block_erase_allow_r <= 1'b1;
      chip_erase_allow_r <= 1'b1;
      read_allow_r <= 1'b1;
    end
    else
    begin
      prog_allow_r <= self_prog_mode ||
        (protection_flag_byte_r[`FCS_BIT_PROG] && !(boot_lock && in_boot));
      block_erase_allow_r <= self_prog_mode ||
        (protection_flag_byte_r[`FCS_BIT_BERS] && !(boot_lock && in_boot));
      chip_erase_allow_r <= self_prog_mode ||
        (protection_flag_byte_r[`FCS_BIT_CERS] && !boot_lock);
      read_allow_r <= self_prog_mode || protection_flag_byte_r[`FCS_BIT_READ];
    end
  end
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: if (rx_valid && rx_data == `FCS_HDR_CMD) state_nxt = S_RXCMD;
      S_SECDATA: state_nxt = S_SECDATA;
      default: state_nxt = state_r;
    endcase
  end
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_r <= S_IDLE;
      idx_r <= 4'h0;
      cmd_r <= `FCS_ZERO8;
      len_r <= `FCS_ZERO8;
      addr_r <= `FCS_ADDR_ZERO;
      end_r <= `FCS_ADDR_ZERO;
      sum_r <= 16'h0000;
      stat_r <= `FCS_ZERO8;
      kind_r <= K_STAT;
      verify_pend_r <= 1'b0;
      tx_pos_r <= 4'h0;
      tx_cnt_r <= 9'h000;
      fsum_r <= `FCS_ZERO8;
      last_frame_r <= 1'b0;
      rd_byte_r <= `FCS_ZERO8;
      rd_pend_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r <= `FCS_ZERO8;
      fl_rd_r <= 1'b0;
      fl_addr_r <= `FCS_ADDR_ZERO;
      protection_flag_byte_r <= `FCS_FLG_INIT;
      boot_cluster_last_block_r <= `FCS_ZERO8;
      security_set_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      fl_rd_r <= 1'b0;
      busy_r <= (state_nxt != S_IDLE) || (state_r != S_IDLE);
      if (chip_erase_done && chip_erase_allow_r)
      begin
        // Only chip erase clears protection; block erase never reaches here
        protection_flag_byte_r <= `FCS_FLG_INIT;
        boot_cluster_last_block_r <= `FCS_ZERO8;
        security_set_r <= 1'b0;
      end
      case (state_r)
        S_IDLE:
        begin
          state_r <= state_nxt;
          idx_r <= 4'h0;
        end
        S_RXCMD:
          if (rx_valid)
          begin
            // Byte order: length, command, parameters, frame checksum, footer
            if (idx_r == 4'h0)
              len_r <= rx_data;
            else if (idx_r == 4'h1)
              cmd_r <= rx_data;
            else
              buf_r[idx_r] <= rx_data;
            idx_r <= idx_r + 4'h1;
            if (idx_r > 4'h0 && idx_r == len_r[3:0] + 4'h2)
            begin
              stat_r <= `FCS_ACK;
              kind_r <= K_STAT;
              state_r <= S_STATUS;
              if (rx_data != `FCS_FTR_LAST)
                stat_r <= `FCS_NACK;
              else if ((cmd_r == `FCS_CMD_CSUM || cmd_r == `FCS_CMD_READ) &&
                (len_r != `FCS_LEN_ADDR_CMD || range_bad))
                stat_r <= `FCS_NACK;
              else if (cmd_r == `FCS_CMD_READ && !read_allow_r)
                stat_r <= `FCS_PROTECT;
              else if (cmd_r == `FCS_CMD_SEC && len_r != `FCS_LEN_SEC_CMD)
                stat_r <= `FCS_NACK;
              else if (cmd_r != `FCS_CMD_CSUM && cmd_r != `FCS_CMD_READ &&
                cmd_r != `FCS_CMD_SEC)
                stat_r <= `FCS_NACK;
              addr_r <= sa;
              end_r <= ea;
              sum_r <= 16'h0000;
              verify_pend_r <= 1'b0;
            end
            else if (idx_r == 4'hA)
              state_r <= S_IDLE;
          end
        S_STATUS:
        begin
          // One-byte status frame for reception, write and verify results
          tx_cnt_r <= {1'b0, `FCS_LEN_ONE};
          rd_byte_r <= stat_r;
          tx_pos_r <= 4'h0;
          last_frame_r <= 1'b1;
          state_r <= S_TX;
        end
        S_SUM:
          if (!rd_pend_r)
          begin
            fl_rd_r <= 1'b1;
            fl_addr_r <= addr_r;
            rd_pend_r <= 1'b1;
          end
          else if (!fl_rd_r)
          begin
            rd_pend_r <= 1'b0;
            sum_r <= sum_r - {8'h00, fl_rdata};
            addr_r <= addr_r + `FCS_ADDR_ONE;
            if (addr_r == end_r)
            begin
              tx_cnt_r <= {1'b0, `FCS_LEN_TWO};
              tx_pos_r <= 4'h0;
              last_frame_r <= 1'b1;
              kind_r <= K_CSUM;
              state_r <= S_TX;
            end
          end
        S_SECDATA:
          if (rx_valid)
          begin
            buf_r[idx_r] <= rx_data;
            idx_r <= idx_r + 4'h1;
            if (idx_r == 4'h5)
              state_r <= S_SECWR;
          end
        S_SECWR:
        begin
          // Header, length, flag, boot block, checksum, footer are buf 0..5
          if (buf_r[5] != `FCS_FTR_LAST || buf_r[1] != `FCS_LEN_TWO)
            stat_r <= `FCS_NACK;
          else if ((security_set_r || reenable) && !self_prog_mode)
            stat_r <= `FCS_PROTECT;
          else if (self_prog_mode && reenable)
            stat_r <= `FCS_PROTECT;
          else
          begin
            stat_r <= `FCS_ACK;
            protection_flag_byte_r <= {`FCS_FLG_FIXED} | buf_r[2];
            boot_cluster_last_block_r <= buf_r[2][`FCS_BIT_BOOT] ?
              `FCS_ZERO8 : buf_r[3];
            security_set_r <= 1'b1;
          end
          verify_pend_r <= 1'b1;
          kind_r <= K_STAT;
          state_r <= S_STATUS;
        end
        S_TX:
          if (!tx_valid_r || tx_ready)
          begin
            tx_valid_r <= 1'b1;
            tx_pos_r <= tx_pos_r + 4'h1;
            case (tx_pos_r)
              4'h0:
              begin
                tx_data_r <= `FCS_HDR_DATA;
                fsum_r <= `FCS_ZERO8;
              end
              4'h1:
              begin
                tx_data_r <= tx_cnt_r[7:0];
                fsum_r <= fsum_r - tx_cnt_r[7:0];
                // Fetch the first data byte before it is due
                if (kind_r == K_READ)
                  state_r <= S_RDWAIT;
              end
              4'h2:
              begin
                if (kind_r == K_CSUM)
                  tx_data_r <= sum_r[15:8];
                else
                  tx_data_r <= rd_byte_r;
                fsum_r <= fsum_r - ((kind_r == K_CSUM) ? sum_r[15:8] : rd_byte_r);
                if (kind_r == K_CSUM)
                  tx_pos_r <= 4'h3;
                else if (tx_cnt_r != `FCS_CNT_ONE)
                begin
                  tx_cnt_r <= tx_cnt_r - `FCS_CNT_ONE;
                  tx_pos_r <= 4'h2;
                  state_r <= S_RDWAIT;
                end
                else
                  tx_pos_r <= 4'h4;
              end
              4'h3:
              begin
                tx_data_r <= sum_r[7:0];
                fsum_r <= fsum_r - sum_r[7:0];
              end
              4'h4:
                tx_data_r <= fsum_r;
              default:
              begin
                tx_data_r <= last_frame_r ? `FCS_FTR_LAST : `FCS_FTR_MORE;
                tx_pos_r <= 4'h0;
                idx_r <= 4'h0;
                state_r <= S_ACKWAIT;
              end
            endcase
          end
        S_RDWAIT:
        begin
          if (tx_ready)
            tx_valid_r <= 1'b0;
          if (!rd_pend_r)
          begin
            fl_rd_r <= 1'b1;
            fl_addr_r <= addr_r;
            rd_pend_r <= 1'b1;
          end
          else if (!fl_rd_r)
          begin
            rd_pend_r <= 1'b0;
            rd_byte_r <= fl_rdata;
            addr_r <= addr_r + `FCS_ADDR_ONE;
            state_r <= S_TX;
          end
        end
        S_ACKWAIT:
        begin
          if (tx_ready)
            tx_valid_r <= 1'b0;
          if (tx_ready || !tx_valid_r)
          begin
            if (verify_pend_r && stat_r != `FCS_NACK && cmd_r == `FCS_CMD_SEC &&
              kind_r == K_STAT)
            begin
              // Verify compares stored flags against what was written
              verify_pend_r <= 1'b0;
              // Command cleared so the verify frame ends the exchange
              cmd_r <= `FCS_ZERO8;
              stat_r <= (protection_flag_byte_r == new_flg || stat_r != `FCS_ACK) ?
                `FCS_ACK : `FCS_NACK;
              state_r <= S_STATUS;
            end
            else if (stat_r != `FCS_ACK || kind_r == K_CSUM)
              state_r <= S_IDLE;
            else if (cmd_r == `FCS_CMD_CSUM)
              state_r <= S_SUM;
            else if (cmd_r == `FCS_CMD_SEC && !verify_pend_r)
              state_r <= S_SECDATA;
            else if (cmd_r == `FCS_CMD_READ)
            begin
              // Wait for the programmer's status frame; its data byte is buf 2
              if (rx_valid)
              begin
                buf_r[idx_r] <= rx_data;
                idx_r <= idx_r + 4'h1;
              end
              if (kind_r == K_STAT || (rx_valid && idx_r == 4'h4))
              begin
                if (kind_r != K_STAT && buf_r[2] == `FCS_NACK)
                begin
                  addr_r <= addr_r - {15'h0000, tx_cnt_r};
                  state_r <= S_IDLE;
                end
                else if (kind_r != K_STAT && last_frame_r)
                  state_r <= S_IDLE;
                else
                begin
                  kind_r <= K_READ;
                  last_frame_r <= (remain <= `FCS_ADDR_FULL);
                  tx_cnt_r <= (remain <= `FCS_ADDR_FULL) ? remain[8:0] : `FCS_CNT_FULL;
                  tx_pos_r <= 4'h0;
                  state_r <= S_TX;
                end
              end
            end
            else
              state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // fcs_cmd
`default_nettype wire

// file: fcs_cmd_checker.sv
// Port-level assertions for the command block
`timescale 1ns/100ps
`default_nettype none
module fcs_cmd_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link transmit
  input wire logic tx_valid_r,
  input wire logic [7:0] tx_data_r,
  input wire logic tx_ready,
  // Core side
  input wire logic self_prog_mode,
  input wire logic chip_erase_done,
  input wire logic [23:0] boot_area_end,
  input wire logic [23:0] op_addr,
  // Security state
  input wire logic [7:0] protection_flag_byte_r,
  input wire logic prog_allow_r,
  input wire logic block_erase_allow_r,
  input wire logic chip_erase_allow_r,
  input wire logic read_allow_r
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // Restore may land one or two cycles after the erase pulse
  sequence restored_s;
    ##[1:2] protection_flag_byte_r == 8'hFF;
  endsequence
  sequence boot_locked_s;
    !protection_flag_byte_r[4] && op_addr < boot_area_end && !self_prog_mode;
  endsequence
  tx_hold_a: assert property (
    tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
    else $error("transmit byte changed before accept");
  read_perm_a: assert property (
    !$past(self_prog_mode) |-> read_allow_r == |($past(protection_flag_byte_r) & 8'h08))
    else $error("read permit does not follow its flag");
  cerase_perm_a: assert property (
    !$past(self_prog_mode) |-> chip_erase_allow_r == (&($past(protection_flag_byte_r) | 8'hEE)))
    else $error("chip erase permit does not follow its flag");
  prog_perm_a: assert property (
    !protection_flag_byte_r[2] && !self_prog_mode |=> !prog_allow_r)
    else $error("programming allowed while disabled");
  berase_perm_a: assert property (
    !protection_flag_byte_r[1] && !self_prog_mode |=> !block_erase_allow_r)
    else $error("block erase allowed while disabled");
  boot_lock_a: assert property (
    boot_locked_s |=> !prog_allow_r && !block_erase_allow_r)
    else $error("boot area rewrite allowed while protected");
  fixed_bits_a: assert property (
    protection_flag_byte_r[7:5] == 3'b111)
    else $error("upper flag bits not one");
  erase_restore_a: assert property (
    chip_erase_done && chip_erase_allow_r && !self_prog_mode |-> restored_s)
    else $error("chip erase did not restore flags");
  no_widen_a: assert property (
    !chip_erase_done && !$past(chip_erase_done)
      |=> (protection_flag_byte_r & ~$past(protection_flag_byte_r)) == 8'h00)
    else $error("flag re-enabled without chip erase");
endmodule // fcs_cmd_checker
`default_nettype wire

// file: fcs_prog_model.sv
// Far-side model: flash array and the programmer's receiver
`timescale 1ns/100ps
`default_nettype none
module fcs_prog_model (
  // Clock
  input wire logic core_clk,
  // Link transmit side
  input wire logic tx_valid_r,
  input wire logic [7:0] tx_data_r,
  output logic tx_ready,
  // Flash port
  input wire logic fl_rd_r,
  input wire logic [23:0] fl_addr_r,
  output logic [7:0] fl_rdata
);
  logic [7:0] got[$];
  int cyc = 0;
  function automatic logic [7:0] fdat(input logic [23:0] a);
    return a[7:0] ^ a[10:3];
  endfunction
  initial tx_ready = 1'b0;
  initial fl_rdata = 8'hA5;
  always @(posedge core_clk)
  begin
    if (tx_valid_r && tx_ready)
      got.push_back(tx_data_r);
  end
  // Stall one cycle in three; read data held until the next request
  always @(negedge core_clk)
  begin
    cyc <= cyc + 1;
    tx_ready <= (cyc % 3) != 2;
    if (fl_rd_r)
      fl_rdata <= fdat(fl_addr_r);
  end
endmodule // fcs_prog_model
`default_nettype wire

// file: flash_checksum_security_read_cmds_tb_top.sv
// Self-checking bench for the checksum, security set and read commands
`timescale 1ns/100ps
`default_nettype none
module flash_checksum_security_read_cmds_tb_top;
  logic core_clk, resetn, rx_valid, tx_valid_r, tx_ready, fl_rd_r, chip_erase_done;
  logic [7:0] rx_data, tx_data_r, fl_rdata, protection_flag_byte, boot_cluster_last_block;
  logic sec, pa, ba, ca, ra, busy;
  logic [23:0] fl_addr_r;
  logic [15:0] e;
  logic [7:0] q[$];
  int mismatches = 0;
  int checked = 0;
  fcs_cmd DUT (.core_clk(core_clk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r), .tx_ready(tx_ready), .fl_rd_r(fl_rd_r),
    .fl_addr_r(fl_addr_r), .fl_rdata(fl_rdata), .self_prog_mode(1'b0),
    .chip_erase_done(chip_erase_done), .boot_area_end(24'h001FFF), .op_addr(24'h000000),
    .protection_flag_byte_r(protection_flag_byte), .boot_cluster_last_block_r(boot_cluster_last_block), .security_set_r(sec),
    .prog_allow_r(pa), .block_erase_allow_r(ba), .chip_erase_allow_r(ca),
    .read_allow_r(ra), .busy_r(busy));
  fcs_prog_model P (.core_clk(core_clk), .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r),
    .tx_ready(tx_ready), .fl_rd_r(fl_rd_r), .fl_addr_r(fl_addr_r), .fl_rdata(fl_rdata));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] a, input logic [7:0] ev);
    checked++;
    if (a !== ev)
    begin
      mismatches++;
      $display("FAIL %0t got %h want %h", $time, a, ev);
    end
  endtask
  task automatic getc(input logic [7:0] ev);
    int n;
    n = 0;
    while (P.got.size() == 0 && n < 10000)
    begin
      @(posedge core_clk);
      n++;
    end
    chk((P.got.size() != 0) ? P.got.pop_front() : 8'hXX, ev);
  endtask
  task automatic tx_byte(input logic [7:0] b);
    @(negedge core_clk);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge core_clk);
    rx_valid = 1'b0;
  endtask
  // Frame sum is zero minus length and payload
  task automatic send(input logic [7:0] hdr, input logic [7:0] d[$]);
    logic [7:0] s;
    s = 8'h00 - 8'(d.size());
    tx_byte(hdr);
    tx_byte(8'(d.size()));
    foreach (d[i])
    begin
      tx_byte(d[i]);
      s = s - d[i];
    end
    tx_byte(s);
    tx_byte(8'h03);
  endtask
  task automatic expf(input logic [7:0] d[$], input logic [7:0] ftr);
    logic [7:0] s;
    s = 8'h00 - 8'(d.size());
    getc(8'h02);
    getc(8'(d.size()));
    foreach (d[i])
    begin
      getc(d[i]);
      s = s - d[i];
    end
    getc(s);
    getc(ftr);
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    $display("FAIL %0t watchdog expired", $time);
    results;
  end
  initial
  begin
    resetn = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    chip_erase_done = 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    send(8'h01, {8'hB0, 8'h00, 8'h08, 8'h00, 8'h00, 8'h0F, 8'hFF});
    expf({8'h06}, 8'h03);
    e = 16'h0000;
    for (int a = 24'h000800; a <= 24'h000FFF; a++)
      e = e - {8'h00, P.fdat(a[23:0])};
    expf({e[15:8], e[7:0]}, 8'h03);
    send(8'h01, {8'hB0, 8'h00, 8'h08, 8'h00, 8'h00, 8'h08, 8'h00});
    expf({8'h15}, 8'h03);
    $display("checksum tests done");
    send(8'h01, {8'h50, 8'h00, 8'h08, 8'h00, 8'h00, 8'h0F, 8'hFF});
    expf({8'h06}, 8'h03);
    for (int f = 0; f < 8; f++)
    begin
      q = {};
      for (int i = 0; i < 256; i++)
        q.push_back(P.fdat(24'h000800 + 24'(f * 256 + i)));
      expf(q, (f == 7) ? 8'h03 : 8'h17);
      send(8'h02, {8'h06});
    end
    $display("read test done");
    send(8'h01, {8'hA0, 8'h00, 8'h00});
    expf({8'h06}, 8'h03);
    send(8'h02, {8'hF1, 8'h00});
    expf({8'h06}, 8'h03);
    expf({8'h06}, 8'h03);
    repeat (3) @(negedge core_clk);
    chk(protection_flag_byte, 8'hF1);
    chk(boot_cluster_last_block, 8'h00);
    chk({7'h00, sec}, 8'h01);
    chk({7'h00, ra}, 8'h00);
    chk({5'h00, pa, ba, ca}, 8'h01);
    send(8'h01, {8'hA0, 8'h00, 8'h00});
    expf({8'h06}, 8'h03);
    send(8'h02, {8'hF0, 8'h00});
    expf({8'h10}, 8'h03);
    expf({8'h06}, 8'h03);
    chk(protection_flag_byte, 8'hF1);
    send(8'h01, {8'h50, 8'h00, 8'h08, 8'h00, 8'h00, 8'h0F, 8'hFF});
    expf({8'h10}, 8'h03);
    $display("security tests done");
    @(negedge core_clk);
    chip_erase_done = 1'b1;
    @(negedge core_clk);
    chip_erase_done = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(protection_flag_byte, 8'hFF);
    chk({7'h00, ra}, 8'h01);
    $display("chip erase test done");
    send(8'h01, {8'hA0, 8'h00, 8'h00});
    expf({8'h06}, 8'h03);
    send(8'h02, {8'hE1, 8'h03});
    expf({8'h06}, 8'h03);
    expf({8'h06}, 8'h03);
    repeat (3) @(negedge core_clk);
    chk(boot_cluster_last_block, 8'h03);
    chk({5'h00, pa, ba, ca}, 8'h00);
    chk({7'h00, busy}, 8'h00);
    $display("boot lock test done");
    results;
  end
endmodule // flash_checksum_security_read_cmds_tb_top
bind fcs_cmd fcs_cmd_checker CHK (.core_clk, .resetn, .tx_valid_r, .tx_data_r, .tx_ready,
  .self_prog_mode, .chip_erase_done, .boot_area_end, .op_addr, .protection_flag_byte_r,
  .prog_allow_r, .block_erase_allow_r, .chip_erase_allow_r, .read_allow_r);
`default_nettype wire
